// *** hdl/sflc_top.sv ***
// Swing frequency modulator with fixed length and event counter.
`timescale 1ns/1ps
`include "sflc_defines.svh"

module sflc_top #(
   parameter int TICK_CYCLES = `SFLC_TICK_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_swing_run,
   input wire logic [15:0] i_center_freq,
   input wire logic [15:0] i_max_freq,
   input wire logic [15:0] i_upper_limit,
   input wire logic [15:0] i_lower_limit,
   input wire logic i_amp_base_sel,
   input wire logic [9:0] i_swing_amp_pct,
   input wire logic [9:0] i_jump_pct,
   input wire logic [14:0] i_cycle_time,
   input wire logic [9:0] i_rise_coef,
   input wire logic i_length_pulse,
   input wire logic i_length_reset,
   input wire logic [15:0] i_set_length,
   input wire logic [15:0] i_pulses_per_meter,
   input wire logic i_count_pulse,
   input wire logic i_count_reset,
   input wire logic [15:0] i_set_count,
   input wire logic [15:0] i_designated_count,
   output logic [15:0] o_freq_ff,
   output logic [1:0] o_phase_ff,
   output logic [15:0] o_actual_length_ff,
   output logic o_length_reached_ff,
   output logic [15:0] o_count_value_ff,
   output logic o_set_count_reached_ff,
   output logic o_designated_reached_ff
);

   sflc_pkg::sflc_phase_t phase_ff;
   sflc_pkg::sflc_phase_t nxt_phase;
   logic [31:0] div_ff;
   logic tick_ff;
   logic [21:0] t_ff;
   logic [21:0] nxt_t;
   logic [15:0] base_w;
   logic [25:0] aw_prod_w;
   logic [15:0] aw_w;
   logic [9:0] jpct_w;
   logic [15:0] j_w;
   logic [16:0] span_w;
   logic [21:0] rise_ms_w;
   logic [21:0] cyc_ms_w;
   logic [21:0] fall_ms_w;
   logic [21:0] len_w;
   logic [38:0] ramp_prod_w;
   logic [16:0] ramp_w;
   logic signed [19:0] off_w;
   logic signed [19:0] sum_w;
   logic [15:0] nxt_freq;
   logic active_w;
   logic [31:0] len_cnt_w;
   logic [31:0] evt_cnt_w;
   logic [35:0] len_scaled_w;
   logic [15:0] ppm_w;
   logic [35:0] len_q_w;
   logic [15:0] nxt_len;
   logic count_hold_w;

   // Clamp a signed value into the window [lo, hi]; below zero reads as zero.
   function automatic logic [15:0] sflc_clamp(input logic signed [19:0] v,
                                              input logic [15:0] lo,
                                              input logic [15:0] hi);
      logic [15:0] r;
      if (v < 20'sh0) begin
         r = 16'h0000;
      end else if (v > 20'sh0FFFF) begin
         r = 16'hFFFF;
      end else begin
         r = v[15:0];
      end
      if (r > hi) begin
         r = hi;
      end
      if (r < lo) begin
         r = lo;
      end
      return r;
   endfunction

   // 1 ms enable from the reference clock; the triangle is paced in whole milliseconds.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         div_ff <= 32'h0000_0000;
         tick_ff <= 1'b0;
      end else if (div_ff >= 32'(TICK_CYCLES - 1)) begin
         div_ff <= 32'h0000_0000;
         tick_ff <= 1'b1;
      end else begin
         div_ff <= div_ff + 32'h0000_0001;
         tick_ff <= 1'b0;
      end
   end

   // Amplitude, jump and ramp durations.
   always_comb begin
      base_w = (i_amp_base_sel == 1'(sflc_pkg::SFLC_BASE_MAX)) ? i_max_freq : i_center_freq;
      aw_prod_w = 26'(base_w * i_swing_amp_pct);
      aw_w = 16'(aw_prod_w / 26'(`SFLC_PCT_FULL));
      jpct_w = (i_jump_pct > `SFLC_JUMP_PCT_MAX) ? `SFLC_JUMP_PCT_MAX : i_jump_pct;
      j_w = 16'(26'(aw_w * jpct_w) / 26'(`SFLC_PCT_FULL));
      span_w = {aw_w, 1'b0} - {1'b0, j_w};
      cyc_ms_w = 22'(i_cycle_time * `SFLC_MS_PER_UNIT);
      rise_ms_w = 22'(25'(i_cycle_time * i_rise_coef) / 25'(`SFLC_COEF_DIV));
      fall_ms_w = cyc_ms_w - rise_ms_w;
      active_w = i_swing_run && (i_swing_amp_pct != 10'h000) && (i_cycle_time != 15'h0000);
   end

   // Ramp position: rise runs from -AW+J to +AW, fall from +AW-J to -AW.
   always_comb begin
      len_w = (phase_ff == sflc_pkg::SFLC_RISE) ? rise_ms_w : fall_ms_w;
      if (len_w == 22'h00_0000) begin
         len_w = 22'h00_0001;
      end
      ramp_prod_w = 39'(span_w * t_ff);
      ramp_w = 17'(ramp_prod_w / 39'(len_w));
      if (ramp_w > span_w) begin
         ramp_w = span_w;
      end
      case (phase_ff)
         sflc_pkg::SFLC_RISE: begin
            off_w = -20'(aw_w) + 20'(j_w) + 20'(ramp_w);
         end
         sflc_pkg::SFLC_FALL: begin
            off_w = 20'(aw_w) - 20'(j_w) - 20'(ramp_w);
         end
         default: begin
            off_w = 20'sh0;
         end
      endcase
      sum_w = 20'(i_center_freq) + off_w;
      nxt_freq = sflc_clamp(sum_w, i_lower_limit, i_upper_limit);
   end

   // Phase sequencing; a reversal happens when the current ramp runs out its time.
   always_comb begin
      nxt_phase = phase_ff;
      nxt_t = t_ff;
      if (!active_w) begin
         nxt_phase = sflc_pkg::SFLC_IDLE;
         nxt_t = 22'h00_0000;
      end else begin
         case (phase_ff)
            sflc_pkg::SFLC_IDLE: begin
               nxt_phase = sflc_pkg::SFLC_RISE;
               nxt_t = 22'h00_0000;
            end
            sflc_pkg::SFLC_RISE: begin
               if (tick_ff && (t_ff + 22'h00_0001 >= rise_ms_w)) begin
                  nxt_phase = sflc_pkg::SFLC_FALL;
                  nxt_t = 22'h00_0000;
               end else if (tick_ff) begin
                  nxt_t = t_ff + 22'h00_0001;
               end
            end
            sflc_pkg::SFLC_FALL: begin
               if (tick_ff && (t_ff + 22'h00_0001 >= fall_ms_w)) begin
                  nxt_phase = sflc_pkg::SFLC_RISE;
                  nxt_t = 22'h00_0000;
               end else if (tick_ff) begin
                  nxt_t = t_ff + 22'h00_0001;
               end
            end
            default: begin
               nxt_phase = sflc_pkg::SFLC_IDLE;
               nxt_t = 22'h00_0000;
            end
         endcase
      end
   end

   // Triangle state and the clamped output frequency.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         phase_ff <= sflc_pkg::SFLC_IDLE;
         t_ff <= 22'h00_0000;
         o_phase_ff <= 2'h0;
         o_freq_ff <= 16'h0000;
      end else begin
         phase_ff <= nxt_phase;
         t_ff <= nxt_t;
         o_phase_ff <= nxt_phase;
         o_freq_ff <= nxt_freq;
      end
   end

   // Length and event pulse counters on their input terminals.
   sflc_pulse_counter u_len_cnt (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_pulse(i_length_pulse),
      .i_clear(i_length_reset),
      .i_hold(1'b0),
      .o_count_ff(len_cnt_w)
   );

   sflc_pulse_counter u_evt_cnt (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_pulse(i_count_pulse),
      .i_clear(i_count_reset),
      .i_hold(count_hold_w),
      .o_count_ff(evt_cnt_w)
   );

   // Length in meters; a zero ratio is read as the smallest legal one to avoid a divide by zero.
   always_comb begin
      ppm_w = (i_pulses_per_meter == 16'h0000) ? 16'h0001 : i_pulses_per_meter;
      len_scaled_w = 36'(len_cnt_w * `SFLC_PPM_SCALE);
      len_q_w = len_scaled_w / 36'(ppm_w);
      nxt_len = (len_q_w > 36'(`SFLC_LEN_MAX)) ? `SFLC_LEN_MAX : len_q_w[15:0];
      count_hold_w = (evt_cnt_w >= 32'(i_set_count));
   end

   // Length reached latches; the reset clears it together with the length itself.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_actual_length_ff <= 16'h0000;
         o_length_reached_ff <= 1'b0;
      end else if (i_length_reset) begin
         o_actual_length_ff <= 16'h0000;
         o_length_reached_ff <= 1'b0;
      end else begin
         o_actual_length_ff <= nxt_len;
         if (o_actual_length_ff > i_set_length) begin
            o_length_reached_ff <= 1'b1;
         end
      end
   end

   // Count flags latch until the counter reset.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_count_value_ff <= 16'h0000;
         o_set_count_reached_ff <= 1'b0;
         o_designated_reached_ff <= 1'b0;
      end else if (i_count_reset) begin
         o_count_value_ff <= 16'h0000;
         o_set_count_reached_ff <= 1'b0;
         o_designated_reached_ff <= 1'b0;
      end else begin
         o_count_value_ff <= evt_cnt_w[15:0];
         if (count_hold_w) begin
            o_set_count_reached_ff <= 1'b1;
         end
         if (evt_cnt_w >= 32'(i_designated_count)) begin
            o_designated_reached_ff <= 1'b1;
         end
      end
   end

   a_zero_amp_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_swing_amp_pct == 10'h000) |=> (phase_ff == sflc_pkg::SFLC_IDLE))
      else $error("Swing active with zero amplitude.");

   a_freq_in_limits: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_lower_limit <= i_upper_limit) |=>
      (o_freq_ff <= $past(i_upper_limit) && o_freq_ff >= $past(i_lower_limit)))
      else $error("Output frequency outside limits.");

   a_jump_half_amp: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ({1'b0, j_w} <= {1'b0, aw_w} - {1'b0, j_w}))
      else $error("Jump exceeds half the amplitude.");

   a_rise_ends_fall: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (active_w && phase_ff == sflc_pkg::SFLC_RISE && tick_ff
       && t_ff + 22'h00_0001 >= rise_ms_w) |=> (phase_ff == sflc_pkg::SFLC_FALL && t_ff == 0))
      else $error("Rise did not reverse on time.");

   a_fall_ends_rise: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (active_w && phase_ff == sflc_pkg::SFLC_FALL && tick_ff
       && t_ff + 22'h00_0001 >= fall_ms_w) |=> (phase_ff == sflc_pkg::SFLC_RISE && t_ff == 0))
      else $error("Fall did not reverse on time.");

   a_length_reach_set: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (o_actual_length_ff > i_set_length && !i_length_reset) |=> o_length_reached_ff)
      else $error("Length reached not raised.");

   a_length_reset_clr: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_length_reset |=> (!o_length_reached_ff && o_actual_length_ff == 16'h0000))
      else $error("Length reset did not clear.");

   a_count_stop_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (count_hold_w && !i_count_reset) |=> (o_set_count_reached_ff && $stable(evt_cnt_w)))
      else $error("Set count reached but not stopped.");

   a_designated_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (evt_cnt_w >= 32'(i_designated_count) && !i_count_reset) |=> o_designated_reached_ff)
      else $error("Designated count flag not raised.");

endmodule

// *** hdl/sflc_defines.svh ***
// Timing counts, reset values and scaling constants of the swing, length and count block.
`ifndef SFLC_DEFINES_SVH
`define SFLC_DEFINES_SVH

// Clock period and the 1 ms timebase that paces the triangle.
`define SFLC_CLK_PERIOD_NS 5
`define SFLC_TICK_TIME_NS 1000000
`define SFLC_TICK_CYCLES (`SFLC_TICK_TIME_NS / `SFLC_CLK_PERIOD_NS)

// Percentages are in 0.1 % units, so 1000 is full scale.
`define SFLC_PCT_FULL 11'h3E8
`define SFLC_JUMP_PCT_MAX 10'h1F4
// Cycle time is in 0.1 s units; one unit is 100 ticks of 1 ms.
`define SFLC_MS_PER_UNIT 7'h64
`define SFLC_COEF_DIV 4'hA
// Pulses per meter is in 0.1 units.
`define SFLC_PPM_SCALE 4'hA
`define SFLC_LEN_MAX 16'hFFFF

// Power-on values that the configuring party should load.
`define SFLC_RST_AMP_BASE 1'h0
`define SFLC_RST_SWING_PCT 10'h000
`define SFLC_RST_JUMP_PCT 10'h000
`define SFLC_RST_CYCLE 15'h0064
`define SFLC_RST_RISE_COEF 10'h1F4
`define SFLC_RST_SET_LEN 16'h03E8
`define SFLC_RST_PPM 16'h03E8
`define SFLC_RST_SET_COUNT 16'h03E8
`define SFLC_RST_DESIG_COUNT 16'h03E8

`endif

// *** hdl/sflc_pkg.sv ***
// Types shared by the swing, length and count block.
package sflc_pkg;

   // Triangle phase, Gray coded along idle, rise, fall.
   typedef enum logic [1:0] {
      SFLC_IDLE = 2'b00,
      SFLC_RISE = 2'b01,
      SFLC_FALL = 2'b11
   } sflc_phase_t;

   // Base of the swing amplitude.
   typedef enum logic {
      SFLC_BASE_CENTER = 1'b0,
      SFLC_BASE_MAX = 1'b1
   } sflc_base_t;

endpackage

// *** hdl/sflc_pulse_counter.sv ***
// Edge counter for a digital input terminal, with clear and hold.
`timescale 1ns/1ps

module sflc_pulse_counter (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_pulse,
   input wire logic i_clear,
   input wire logic i_hold,
   output logic [31:0] o_count_ff
);

   logic prev_ff;

   // Previous level of the terminal, for rising edge detection.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= i_pulse;
      end
   end

   // Clear wins over a pulse so a reset always starts from zero.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_count_ff <= 32'h0000_0000;
      end else if (i_clear) begin
         o_count_ff <= 32'h0000_0000;
      end else if (i_pulse && !prev_ff && !i_hold && o_count_ff != 32'hFFFF_FFFF) begin
         o_count_ff <= o_count_ff + 32'h0000_0001;
      end
   end

   a_clear_zeroes: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_clear |=> o_count_ff == 32'h0000_0000) else $error("Counter not zero after clear.");

   a_hold_freezes: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (i_hold && !i_clear) |=> $stable(o_count_ff)) else $error("Counter moved while held.");

endmodule

// *** verif/sflc_terminal_model.sv ***
// Model of the digital input terminals that feed length and count pulses.
`timescale 1ns/1ps

module sflc_terminal_model (
   input wire logic i_ref_clk,
   output logic o_length_pulse,
   output logic o_count_pulse
);
   // Both terminals idle low; every level is held at least two clocks.
   initial begin
      o_length_pulse = 1'b0;
      o_count_pulse = 1'b0;
   end

   // Length pulses arrive on the terminal given to length counting.
   task automatic send_length(input int n);
      repeat (n) begin
         @(negedge i_ref_clk) o_length_pulse = 1'b1;
         repeat (2) @(negedge i_ref_clk);
         o_length_pulse = 1'b0;
         @(negedge i_ref_clk);
      end
   endtask

   // Count pulses arrive on their own terminal, so neither path sees the other's edges.
   task automatic send_count(input int n);
      repeat (n) begin
         @(negedge i_ref_clk) o_count_pulse = 1'b1;
         repeat (2) @(negedge i_ref_clk);
         o_count_pulse = 1'b0;
         @(negedge i_ref_clk);
      end
   endtask
endmodule

// *** verif/sflc_top_tb.sv ***
// Self-checking testbench for the swing, length and count block.
`timescale 1ns/1ps

module sflc_top_tb;
   localparam int TICK = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic run = 1'b0;
   logic base = 1'b0;
   logic len_rst = 1'b0;
   logic cnt_rst = 1'b0;
   logic [15:0] center = 16'h03E8, maxf = 16'h07D0, upper = 16'hFFFF, lower = 16'h0000;
   logic [9:0] pct = 10'h000, jpct = 10'h000, coef = 10'h1F4;
   logic [14:0] cyc = 15'h0001;
   logic [15:0] set_len = 16'h0003, ppm = 16'h0014, set_cnt = 16'h0005, desig = 16'h0003;
   logic len_pulse, cnt_pulse;
   logic [15:0] freq, act_len, cnt_val;
   logic [1:0] phase;
   logic len_hit, set_hit, des_hit;
   int num_errors = 0;
   int check_count = 0;

   // Half period of 2.5 ns gives the 200 MHz clock.
   always #2.5 clk = ~clk;

   sflc_top #(.TICK_CYCLES(TICK)) u_sflc_top (
      .i_ref_clk(clk), .i_rst(rst), .i_swing_run(run), .i_center_freq(center),
      .i_max_freq(maxf), .i_upper_limit(upper), .i_lower_limit(lower),
      .i_amp_base_sel(base), .i_swing_amp_pct(pct), .i_jump_pct(jpct),
      .i_cycle_time(cyc), .i_rise_coef(coef), .i_length_pulse(len_pulse),
      .i_length_reset(len_rst), .i_set_length(set_len), .i_pulses_per_meter(ppm),
      .i_count_pulse(cnt_pulse), .i_count_reset(cnt_rst), .i_set_count(set_cnt),
      .i_designated_count(desig), .o_freq_ff(freq), .o_phase_ff(phase),
      .o_actual_length_ff(act_len), .o_length_reached_ff(len_hit),
      .o_count_value_ff(cnt_val), .o_set_count_reached_ff(set_hit),
      .o_designated_reached_ff(des_hit)
   );

   sflc_terminal_model u_sflc_terminal_model (
      .i_ref_clk(clk), .o_length_pulse(len_pulse), .o_count_pulse(cnt_pulse)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Waits for a phase under a bound; a hang ends the run as a failure.
   task automatic wait_phase(input logic [1:0] ph, output int n);
      n = 0;
      while (phase !== ph && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000) begin
         num_errors++;
         close_out();
      end
   endtask

   // Idle output is the centre value pushed into the limit window.
   task automatic test_idle();
      upper = 16'h0384;
      repeat (2) @(negedge clk);
      check(freq, 32'h384);
      upper = 16'hFFFF;
      lower = 16'h04B0;
      repeat (2) @(negedge clk);
      check(freq, 32'h4B0);
      lower = 16'h0000;
      run = 1'b1;
      repeat (TICK * 3) @(negedge clk);
      check(phase, 32'h0);
      check(freq, 32'h3E8);
      run = 1'b0;
      $display("test_idle done");
   endtask

   // One swing period; the ramp lengths tolerate one tick of timebase phase.
   task automatic test_swing(input logic b, input logic [9:0] p, input logic [9:0] j,
                             input logic [9:0] c, input logic [15:0] hi,
                             input int lo_f, input int hi_f, input int rise);
      int n;
      base = b;
      pct = p;
      jpct = j;
      coef = c;
      upper = hi;
      run = 1'b1;
      wait_phase(2'b01, n);
      // The frequency register trails the phase register by one clock.
      @(negedge clk);
      check(freq, lo_f);
      wait_phase(2'b11, n);
      @(negedge clk);
      check(freq, hi_f);
      // The clock spent above is added back; the first rise may run up to one tick short.
      check(n + 1 >= (rise - 1) * TICK + 1 && n + 1 <= rise * TICK, 1);
      wait_phase(2'b01, n);
      check(n + 1 >= (100 - rise) * TICK - 2 && n + 1 <= (100 - rise) * TICK + 2, 1);
      run = 1'b0;
      upper = 16'hFFFF;
      repeat (2) @(negedge clk);
      $display("test_swing done");
   endtask

   // Length is pulses times ten over pulses per meter, truncated; 2 pulses make 1 m.
   task automatic test_length();
      u_sflc_terminal_model.send_length(7);
      repeat (4) @(negedge clk);
      check(act_len, 32'h3);
      check(len_hit, 32'h0);
      u_sflc_terminal_model.send_length(1);
      repeat (4) @(negedge clk);
      check(act_len, 32'h4);
      check(len_hit, 32'h1);
      len_rst = 1'b1;
      @(negedge clk);
      len_rst = 1'b0;
      repeat (3) @(negedge clk);
      check({act_len, len_hit}, 32'h0);
      $display("test_length done");
   endtask

   // Designated target 3 sits below set target 5, so counting goes on past it.
   task automatic test_count();
      u_sflc_terminal_model.send_count(3);
      repeat (4) @(negedge clk);
      // Count 3 meets the designated target but not the set target.
      check({cnt_val, des_hit, set_hit}, 32'hE);
      u_sflc_terminal_model.send_count(3);
      repeat (4) @(negedge clk);
      check({cnt_val, des_hit, set_hit}, 32'h17);
      cnt_rst = 1'b1;
      @(negedge clk);
      cnt_rst = 1'b0;
      repeat (3) @(negedge clk);
      check({cnt_val, des_hit, set_hit}, 32'h0);
      $display("test_count done");
   endtask

   // Main sequence: reset for four cycles, then each scenario in turn.
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      test_idle();
      test_swing(1'b0, 10'h064, 10'h0C8, 10'h12C, 16'hFFFF, 920, 1080, 30);
      test_swing(1'b1, 10'h064, 10'h258, 10'h1F4, 16'h041A, 900, 1050, 50);
      test_length();
      test_count();
      close_out();
   end
endmodule
